/* File: hw/wlc_top.sv */
// dual-window limit checker with ttl fail outputs
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
module wlc_top
  import wlc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        meas_valid_i,
  input  wire logic [31:0] chan_a_pwr_i,
  input  wire logic [31:0] chan_b_pwr_i,
  output logic             meas_ready_o,
  output logic             ttl_upper_o,
  output logic             ttl_lower_o,
  output logic      [1:0]  over_lmt_o,
  output logic      [1:0]  under_lmt_o,
  output logic      [1:0]  log_err_o,
  output logic             irq_o
);

  // register file state
  logic [31:0]        ctrl_reg, ctrl_next;
  logic [31:0]        cfg_reg [2], cfg_next [2];
  logic signed [31:0] up_reg [2], up_next [2];
  logic signed [31:0] lo_reg [2], lo_next [2];
  logic signed [31:0] chup_reg [2], chup_next [2];
  logic signed [31:0] chlo_reg [2], chlo_next [2];
  logic [INT_W-1:0]   ist_reg, ist_next, ien_reg, ien_next;
  logic [31:0]        rdata_reg, rdata_next;
  // engine state
  wlc_state_t         st_reg, st_next;
  logic               w_reg, w_next;
  logic [31:0]        pa_reg, pa_next, pb_reg, pb_next;
  logic [31:0]        conv_reg, conv_next, den_reg, den_next;
  logic signed [31:0] first_reg, first_next;
  logic [47:0]        dvd_reg, dvd_next;
  logic [32:0]        rem_reg, rem_next;
  logic [5:0]         cnt_reg, cnt_next;
  logic signed [31:0] res_reg [2], res_next [2];
  logic [1:0]         over_reg, over_next, under_reg, under_next, lerr_reg, lerr_next;
  logic               ttlu_reg, ttlu_next, ttll_reg, ttll_next;
  logic [INT_W-1:0]   ev;
  // datapath helpers
  logic [2:0]         mode;
  logic [1:0]         units;
  logic               is_diff, is_ratio, use_b;
  logic [31:0]        px, py;
  logic [32:0]        diff, sub;
  logic [31:0]        mag;
  logic signed [31:0] cdb, lim_u, lim_l;
  logic               act, ue, le, ovr, und;

  wlc_lin2db u_lin2db (
    .lin_i (conv_reg),
    .cdb_o (cdb)
  );

  function automatic logic [4:0] win_addr(input int i, input logic [4:0] off);
    win_addr = 5'(A_WIN_BASE + 5'(i) * A_WIN_STRIDE + off);
  endfunction : win_addr

  function automatic logic signed [31:0] clamp_lim(input logic [1:0] u, input logic signed [31:0] v);
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    hi = (u == U_DB) ? DB_MAX : DBM_MAX;
    lo = (u == U_DB) ? DB_MIN : DBM_MIN;
    if (u == U_W || u == U_PCT) begin
      clamp_lim = v;
    end else if (v > hi) begin
      clamp_lim = hi;
    end else if (v < lo) begin
      clamp_lim = lo;
    end else begin
      clamp_lim = v;
    end
  endfunction : clamp_lim

  function automatic logic fail_sel(input logic [1:0] c, input logic o, input logic u);
    fail_sel = (c == COND_OVER) ? o : (c == COND_UNDER) ? u : (o | u);
  endfunction : fail_sel

  // register bus and interrupt state
  always_comb begin
    ctrl_next  = ctrl_reg;
    ien_next   = ien_reg;
    rdata_next = 32'h00000000;
    for (int i = 0; i < 2; i++) begin
      cfg_next[i]  = cfg_reg[i];
      up_next[i]   = up_reg[i];
      lo_next[i]   = lo_reg[i];
      chup_next[i] = clamp_lim(U_DBM, chup_reg[i]);
      chlo_next[i] = clamp_lim(U_DBM, chlo_reg[i]);
    end
    // event set wins over a same-cycle clear
    ist_next = ist_reg | ev;
    if (reg_wr_i) begin
      if (reg_addr_i == A_CTRL) ctrl_next = reg_wdata_i;
      if (reg_addr_i == A_INT_EN) ien_next = reg_wdata_i[INT_W-1:0];
      if (reg_addr_i == A_INT_CLR) ist_next = (ist_reg & ~reg_wdata_i[INT_W-1:0]) | ev;
      if (reg_addr_i == A_CHA_UP) chup_next[0] = clamp_lim(U_DBM, reg_wdata_i);
      if (reg_addr_i == A_CHA_LO) chlo_next[0] = clamp_lim(U_DBM, reg_wdata_i);
      if (reg_addr_i == A_CHB_UP) chup_next[1] = clamp_lim(U_DBM, reg_wdata_i);
      if (reg_addr_i == A_CHB_LO) chlo_next[1] = clamp_lim(U_DBM, reg_wdata_i);
      for (int i = 0; i < 2; i++) begin
        if (reg_addr_i == win_addr(i, O_CFG)) begin
          cfg_next[i] = {24'h000000, reg_wdata_i[7:0]};
          if (reg_wdata_i[F_UNITS_LSB +: 2] != cfg_reg[i][F_UNITS_LSB +: 2]) begin
            unique case (reg_wdata_i[F_UNITS_LSB +: 2])
              U_DB: begin
                up_next[i] = DB_DEF_UP;
                lo_next[i] = DB_DEF_LO;
              end
              U_DBM: begin
                up_next[i] = DBM_DEF_UP;
                lo_next[i] = DBM_DEF_LO;
              end
              U_W, U_PCT: begin
                up_next[i] = LIN_DEF_UP;
                lo_next[i] = LIN_DEF_LO;
              end
            endcase
          end
        end
        if (reg_addr_i == win_addr(i, O_UP)) up_next[i] = clamp_lim(cfg_reg[i][F_UNITS_LSB +: 2], reg_wdata_i);
        if (reg_addr_i == win_addr(i, O_LO)) lo_next[i] = clamp_lim(cfg_reg[i][F_UNITS_LSB +: 2], reg_wdata_i);
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == A_CTRL) rdata_next = ctrl_reg;
      if (reg_addr_i == A_CHA_UP) rdata_next = chup_reg[0];
      if (reg_addr_i == A_CHA_LO) rdata_next = chlo_reg[0];
      if (reg_addr_i == A_CHB_UP) rdata_next = chup_reg[1];
      if (reg_addr_i == A_CHB_LO) rdata_next = chlo_reg[1];
      if (reg_addr_i == A_STATUS) rdata_next = {25'h0000000, st_reg != ST_IDLE, lerr_reg, under_reg, over_reg};
      if (reg_addr_i == A_INT_STAT) rdata_next = {26'h0000000, ist_reg};
      if (reg_addr_i == A_INT_EN) rdata_next = {26'h0000000, ien_reg};
      for (int i = 0; i < 2; i++) begin
        if (reg_addr_i == win_addr(i, O_CFG)) rdata_next = cfg_reg[i];
        if (reg_addr_i == win_addr(i, O_UP)) rdata_next = up_reg[i];
        if (reg_addr_i == win_addr(i, O_LO)) rdata_next = lo_reg[i];
        if (reg_addr_i == win_addr(i, O_RES)) rdata_next = res_reg[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg  <= CTRL_RST;
      ist_reg   <= '0;
      ien_reg   <= '0;
      rdata_reg <= 32'h00000000;
      for (int i = 0; i < 2; i++) begin
        cfg_reg[i]  <= CFG_RST;
        up_reg[i]   <= DBM_DEF_UP;
        lo_reg[i]   <= DBM_DEF_LO;
        chup_reg[i] <= DBM_DEF_UP;
        chlo_reg[i] <= DBM_DEF_LO;
      end
    end else begin
      ctrl_reg  <= ctrl_next;
      ist_reg   <= ist_next;
      ien_reg   <= ien_next;
      rdata_reg <= rdata_next;
      cfg_reg   <= cfg_next;
      up_reg    <= up_next;
      lo_reg    <= lo_next;
      chup_reg  <= chup_next;
      chlo_reg  <= chlo_next;
    end
  end

  // operand selection for the window being processed
  always_comb begin
    mode     = cfg_reg[w_reg][F_MODE_LSB +: 3];
    units    = cfg_reg[w_reg][F_UNITS_LSB +: 2];
    is_diff  = (mode == MD_AMB) || (mode == MD_BMA);
    is_ratio = (mode == MD_ADB) || (mode == MD_BDA);
    use_b    = (mode == MD_B) || (mode == MD_BMA) || (mode == MD_BDA);
    px       = use_b ? pb_reg : pa_reg;
    py       = use_b ? pa_reg : pb_reg;
    diff     = {1'b0, px} - (is_diff ? {1'b0, py} : 33'h000000000);
    mag      = diff[32] ? 32'(-diff) : diff[31:0];
    sub      = {rem_reg[31:0], dvd_reg[47]} - {1'b0, den_reg};
    // one limit set: channel or window
    if (ctrl_reg[C_CHAN_SEL]) begin
      act   = ctrl_reg[C_CHAN_EN] && !is_diff && !is_ratio && units == U_DBM;
      lim_u = chup_reg[use_b];
      lim_l = chlo_reg[use_b];
      ue    = 1'b1;
      le    = 1'b1;
    end else begin
      act   = cfg_reg[w_reg][F_CHK];
      lim_u = up_reg[w_reg];
      lim_l = lo_reg[w_reg];
      ue    = cfg_reg[w_reg][F_UEN];
      le    = cfg_reg[w_reg][F_LEN];
    end
    ovr = act && ue && (res_reg[w_reg] > lim_u);
    und = act && le && (res_reg[w_reg] < lim_l);
  end

  // measurement engine
  always_comb begin
    st_next    = st_reg;
    w_next     = w_reg;
    pa_next    = pa_reg;
    pb_next    = pb_reg;
    conv_next  = conv_reg;
    den_next   = den_reg;
    first_next = first_reg;
    dvd_next   = dvd_reg;
    rem_next   = rem_reg;
    cnt_next   = cnt_reg;
    res_next   = res_reg;
    over_next  = over_reg;
    under_next = under_reg;
    lerr_next  = lerr_reg;
    ev         = '0;
    unique case (st_reg)
      ST_IDLE: begin
        if (meas_valid_i) begin
          pa_next = chan_a_pwr_i;
          pb_next = chan_b_pwr_i;
          w_next  = 1'b0;
          st_next = ST_CALC;
        end
      end
      ST_CALC: begin
        lerr_next[w_reg] = 1'b0;
        if (is_ratio && units == U_PCT) begin
          dvd_next = 48'(px) * PCT_SCALE;
          den_next = py;
          rem_next = 33'h000000000;
          cnt_next = 6'h00;
          st_next  = ST_DIV;
        end else if (is_ratio) begin
          conv_next = px;
          st_next   = ST_CONV1;
        end else if (units == U_W || units == U_PCT) begin
          res_next[w_reg] = 32'(diff);
          st_next         = ST_CHECK;
        end else begin
          conv_next        = mag;
          lerr_next[w_reg] = is_diff && diff[32];
          st_next          = ST_CONV1;
        end
      end
      ST_DIV: begin
        dvd_next = {dvd_reg[46:0], !sub[32]};
        rem_next = sub[32] ? {rem_reg[31:0], dvd_reg[47]} : sub;
        cnt_next = cnt_reg + 6'h01;
        if (cnt_reg == DIV_LAST) begin
          res_next[w_reg] = (den_reg == 32'h00000000 || |dvd_next[47:31]) ? RES_MAX : dvd_next[31:0];
          st_next         = ST_CHECK;
        end
      end
      ST_CONV1: begin
        if (is_ratio) begin
          first_next = cdb;
          conv_next  = py;
          st_next    = ST_CONV2;
        end else begin
          res_next[w_reg] = cdb;
          st_next         = ST_CHECK;
        end
      end
      ST_CONV2: begin
        // ratio in dB is a log difference
        res_next[w_reg] = first_reg - cdb;
        st_next         = ST_CHECK;
      end
      ST_CHECK: begin
        // fresh flags on each new result
        over_next[w_reg]           = ovr;
        under_next[w_reg]          = und;
        ev[I_OVER_LSB + w_reg]     = ovr;
        ev[I_UNDER_LSB + w_reg]    = und;
        ev[I_LOGERR_LSB + w_reg]   = lerr_reg[w_reg];
        w_next                     = 1'b1;
        st_next                    = w_reg ? ST_IDLE : ST_CALC;
      end
      // two state codes are unused; fall back to idle
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    ttlu_next = (ctrl_reg[C_TTL_EN] && fail_sel(ctrl_reg[C_COND_LSB +: 2], over_reg[0], under_reg[0]))
                ? ctrl_reg[C_POL_HI] : !ctrl_reg[C_POL_HI];
    ttll_next = (ctrl_reg[C_TTL_EN] && fail_sel(ctrl_reg[C_COND_LSB +: 2], over_reg[1], under_reg[1]))
                ? ctrl_reg[C_POL_HI] : !ctrl_reg[C_POL_HI];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg    <= ST_IDLE;
      w_reg     <= 1'b0;
      pa_reg    <= 32'h00000000;
      pb_reg    <= 32'h00000000;
      conv_reg  <= 32'h00000000;
      den_reg   <= 32'h00000000;
      first_reg <= 32'sh00000000;
      dvd_reg   <= 48'h000000000000;
      rem_reg   <= 33'h000000000;
      cnt_reg   <= 6'h00;
      res_reg   <= '{default: 32'sh00000000};
      over_reg  <= 2'h0;
      under_reg <= 2'h0;
      lerr_reg  <= 2'h0;
      ttlu_reg  <= 1'b0;
      ttll_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      w_reg     <= w_next;
      pa_reg    <= pa_next;
      pb_reg    <= pb_next;
      conv_reg  <= conv_next;
      den_reg   <= den_next;
      first_reg <= first_next;
      dvd_reg   <= dvd_next;
      rem_reg   <= rem_next;
      cnt_reg   <= cnt_next;
      res_reg   <= res_next;
      over_reg  <= over_next;
      under_reg <= under_next;
      lerr_reg  <= lerr_next;
      ttlu_reg  <= ttlu_next;
      ttll_reg  <= ttll_next;
    end
  end

  assign reg_rdata_o  = rdata_reg;
  assign meas_ready_o = (st_reg == ST_IDLE);
  assign ttl_upper_o  = ttlu_reg;
  assign ttl_lower_o  = ttll_reg;
  assign over_lmt_o   = over_reg;
  assign under_lmt_o  = under_reg;
  assign log_err_o    = lerr_reg;
  assign irq_o        = |(ist_reg & ien_reg);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_neg_log;
    st_reg == ST_CALC && is_diff && !is_ratio && diff[32] && (units == U_DBM || units == U_DB);
  endsequence
  sequence s_div_start;
    st_reg == ST_CALC && is_ratio && units == U_PCT;
  endsequence

  AST_TTL_OFF: assert property ($past(!ctrl_reg[C_TTL_EN]) |-> ttl_upper_o == !$past(ctrl_reg[C_POL_HI])
    && ttl_lower_o == !$past(ctrl_reg[C_POL_HI])) else $error("ttl output shows failure while disabled");
  AST_POL_UP: assert property ($past(ctrl_reg[C_TTL_EN] && ctrl_reg[C_COND_LSB +: 2] == COND_EITHER
    && (over_reg[0] || under_reg[0])) |-> ttl_upper_o == $past(ctrl_reg[C_POL_HI]))
    else $error("upper ttl output not at failing level");
  AST_COND_OVER: assert property ($past(ctrl_reg[C_TTL_EN] && ctrl_reg[C_COND_LSB +: 2] == COND_OVER
    && !over_reg[1]) |-> ttl_lower_o == !$past(ctrl_reg[C_POL_HI])) else $error("lower ttl fails without over");
  AST_LOWER_OUT: assert property ($past(ctrl_reg[C_TTL_EN] && ctrl_reg[C_COND_LSB +: 2] == COND_UNDER
    && under_reg[1]) |-> ttl_lower_o == $past(ctrl_reg[C_POL_HI])) else $error("lower ttl missed under");
  AST_OVER_CMP: assert property (st_reg == ST_CHECK && !ctrl_reg[C_CHAN_SEL] && cfg_reg[w_reg][F_CHK]
    && cfg_reg[w_reg][F_UEN] && res_reg[w_reg] > up_reg[w_reg] |=> over_reg[$past(w_reg)])
    else $error("over limit not flagged");
  AST_RANGE: assert property (cfg_reg[0][F_UNITS_LSB +: 2] == U_DBM |-> up_reg[0] <= DBM_MAX
    && lo_reg[0] >= DBM_MIN) else $error("dBm limit out of range");
  AST_DEFAULT_DB: assert property (reg_wr_i && reg_addr_i == win_addr(0, O_CFG)
    && reg_wdata_i[F_UNITS_LSB +: 2] == U_DB && cfg_reg[0][F_UNITS_LSB +: 2] != U_DB
    |=> up_reg[0] == DB_DEF_UP && lo_reg[0] == DB_DEF_LO) else $error("dB defaults not loaded");
  AST_KEEP_LIM: assert property (reg_wr_i && reg_addr_i == win_addr(1, O_CFG)
    && reg_wdata_i[F_UNITS_LSB +: 2] == cfg_reg[1][F_UNITS_LSB +: 2] |=> $stable(up_reg[1]) && $stable(lo_reg[1]))
    else $error("limits lost on check toggle");
  AST_LOG_ERR: assert property (s_neg_log ##1 st_reg == ST_CONV1 |=> res_reg[w_reg] >= LSB_CDB
    && lerr_reg[w_reg]) else $error("negative log difference not handled");
  AST_DIV_LEN: assert property (s_div_start |=> (st_reg == ST_DIV)[*8] ##41 st_reg == ST_CHECK)
    else $error("percent division length wrong");
  AST_CHAN_ONLY: assert property (st_reg == ST_CHECK && ctrl_reg[C_CHAN_SEL] && (is_diff || is_ratio)
    |=> !over_reg[$past(w_reg)] && !under_reg[$past(w_reg)]) else $error("window limits used in channel mode");
  AST_DONE: assert property (st_reg == ST_IDLE && meas_valid_i |-> ##[4:110] st_reg == ST_IDLE)
    else $error("sample not fully evaluated");

endmodule : wlc_top

/* File: pkg/wlc_pkg.sv */
// shared constants for the window limit checker
package wlc_pkg;

  // register word indices on the plain register port
  localparam logic [4:0]  A_CTRL       = 5'h00;
  localparam logic [4:0]  A_WIN_BASE   = 5'h01;
  localparam logic [4:0]  A_WIN_STRIDE = 5'h04;
  localparam logic [4:0]  O_CFG        = 5'h00;
  localparam logic [4:0]  O_UP         = 5'h01;
  localparam logic [4:0]  O_LO         = 5'h02;
  localparam logic [4:0]  O_RES        = 5'h03;
  localparam logic [4:0]  A_CHA_UP     = 5'h09;
  localparam logic [4:0]  A_CHA_LO     = 5'h0A;
  localparam logic [4:0]  A_CHB_UP     = 5'h0B;
  localparam logic [4:0]  A_CHB_LO     = 5'h0C;
  localparam logic [4:0]  A_STATUS     = 5'h0D;
  localparam logic [4:0]  A_INT_STAT   = 5'h0E;
  localparam logic [4:0]  A_INT_EN     = 5'h0F;
  localparam logic [4:0]  A_INT_CLR    = 5'h10;

  // control word fields
  localparam int          C_TTL_EN     = 0;
  localparam int          C_POL_HI     = 1;
  localparam int          C_COND_LSB   = 2;
  localparam int          C_CHAN_SEL   = 4;
  localparam int          C_CHAN_EN    = 5;
  localparam logic [1:0]  COND_OVER    = 2'h0;
  localparam logic [1:0]  COND_UNDER   = 2'h1;
  localparam logic [1:0]  COND_EITHER  = 2'h2;

  // window configuration fields
  localparam int          F_MODE_LSB   = 0;
  localparam int          F_UNITS_LSB  = 3;
  localparam int          F_CHK        = 5;
  localparam int          F_UEN        = 6;
  localparam int          F_LEN        = 7;
  localparam logic [2:0]  MD_A         = 3'h0;
  localparam logic [2:0]  MD_B         = 3'h1;
  localparam logic [2:0]  MD_AMB       = 3'h2;
  localparam logic [2:0]  MD_BMA       = 3'h3;
  localparam logic [2:0]  MD_ADB       = 3'h4;
  localparam logic [2:0]  MD_BDA       = 3'h5;
  localparam logic [1:0]  U_DBM        = 2'h0;
  localparam logic [1:0]  U_DB         = 2'h1;
  localparam logic [1:0]  U_W          = 2'h2;
  localparam logic [1:0]  U_PCT        = 2'h3;

  // reset values
  localparam logic [31:0] CTRL_RST     = 32'h00000002;
  localparam logic [31:0] CFG_RST      = 32'h000000C0;

  // limit ranges and defaults, hundredths of a dB (linear defaults in raw units)
  localparam logic signed [31:0] DB_MAX      = 32'sh00004E20;
  localparam logic signed [31:0] DB_MIN      = -32'sh00004650;
  localparam logic signed [31:0] DBM_MAX     = 32'sh000059D8;
  localparam logic signed [31:0] DBM_MIN     = -32'sh00003A98;
  localparam logic signed [31:0] DB_DEF_UP   = 32'sh00001770;
  localparam logic signed [31:0] DB_DEF_LO   = -32'sh00002EE0;
  localparam logic signed [31:0] DBM_DEF_UP  = 32'sh00002328;
  localparam logic signed [31:0] DBM_DEF_LO  = -32'sh00002328;
  localparam logic signed [31:0] LIN_DEF_UP  = 32'sh7FFFFFFF;
  localparam logic signed [31:0] LIN_DEF_LO  = 32'sh00000000;

  // log conversion: 1 lsb of linear power is 1 pW (-90 dBm)
  localparam logic [9:0]         LOG_K       = 10'h12D;
  localparam logic signed [31:0] LSB_CDB     = -32'sh00002328;
  localparam logic signed [31:0] LOG_FLOOR   = -32'sh00004E20;
  localparam logic [47:0]        PCT_SCALE   = 48'h000000002710;
  localparam logic [5:0]         DIV_LAST    = 6'h2F;
  localparam logic signed [31:0] RES_MAX     = 32'sh7FFFFFFF;

  // interrupt and status layout
  localparam int          I_OVER_LSB   = 0;
  localparam int          I_UNDER_LSB  = 2;
  localparam int          I_LOGERR_LSB = 4;
  localparam int          INT_W        = 6;
  localparam int          S_BUSY       = 6;

  typedef enum logic [2:0] {ST_IDLE, ST_CALC, ST_DIV, ST_CONV1, ST_CONV2, ST_CHECK} wlc_state_t;

endpackage : wlc_pkg

/* File: hw/wlc_lin2db.sv */
// linear power to hundredths of a dBm, piecewise-linear log2
module wlc_lin2db
  import wlc_pkg::*;
(
  input  wire logic [31:0]        lin_i,
  output logic signed [31:0]      cdb_o
);

  logic [4:0]  idx;
  logic [31:0] norm;
  logic [12:0] log2q;
  logic [22:0] prod;

  // chord interpolation between octaves; error stays below 0.3 dB
  always_comb begin
    idx = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (lin_i[i]) begin
        idx = 5'(i);
      end
    end
    norm  = lin_i << (5'h1F - idx);
    log2q = {idx, norm[30:23]};
    prod  = {10'h000, log2q} * {13'h0000, LOG_K};
    if (lin_i == 32'h00000000) begin
      cdb_o = LOG_FLOOR;
    end else begin
      cdb_o = $signed({17'h00000, prod[22:8]}) + LSB_CDB;
    end
  end

endmodule : wlc_lin2db

/* File: verif/wlc_meas_src.sv */
// measurement source standing in for the corrected channel power path
module wlc_meas_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic        meas_ready_i,
  output logic             meas_valid_o,
  output logic      [31:0] chan_a_pwr_o,
  output logic      [31:0] chan_b_pwr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meas_valid_o <= 1'b0;
      chan_a_pwr_o <= 32'h00000000;
      chan_b_pwr_o <= 32'h00000000;
    end else if (go_i && !meas_valid_o && meas_ready_i) begin
      meas_valid_o <= 1'b1;
      chan_a_pwr_o <= a_i;
      chan_b_pwr_o <= b_i;
    end else begin
      meas_valid_o <= 1'b0;
      // not held past the sample, so a late read of the lines is caught
      chan_a_pwr_o <= ~chan_a_pwr_o;
      chan_b_pwr_o <= ~chan_b_pwr_o;
    end
  end
endmodule : wlc_meas_src

/* File: verif/wlc_top_tb_top.sv */
// bench for the dual-window limit checker
module wlc_top_tb_top
  import wlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wr, rd, go, mv, rdy, tu, tl, irq;
  logic [4:0]  addr;
  logic [31:0] wdata, a_v, b_v, rdata, ca, cb;
  logic [1:0]  ov, un, le;
  int          fail_count = 0;
  int          tests_run = 0;

  wlc_meas_src src_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .a_i(a_v), .b_i(b_v), .meas_ready_i(rdy),
    .meas_valid_o(mv), .chan_a_pwr_o(ca), .chan_b_pwr_o(cb));
  wlc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .meas_valid_i(mv), .chan_a_pwr_i(ca), .chan_b_pwr_i(cb),
    .meas_ready_o(rdy), .ttl_upper_o(tu), .ttl_lower_o(tl), .over_lmt_o(ov), .under_lmt_o(un),
    .log_err_o(le), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask : wrr

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd   <= 1'b0;
    @(negedge clk_i);
    chk(rdata, e);
  endtask : rdc

  // one sample through the source, then both windows settle
  task automatic meas(input logic [31:0] a, input logic [31:0] b);
    int n;
    @(posedge clk_i);
    a_v <= a;
    b_v <= b;
    go  <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (rdy !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 200) begin
      fail_count++;
      give_verdict();
    end
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : meas

  task automatic t_reset;
    rdc(A_CTRL, CTRL_RST);
    rdc(5'h01, CFG_RST);
    rdc(5'h02, DBM_DEF_UP);
    rdc(5'h03, DBM_DEF_LO);
    rdc(5'h1F, 32'h00000000);
    chk({31'h0, tu}, 32'h00000000);
  endtask : t_reset

  task automatic t_range;
    wrr(5'h01, 32'h000000E8);
    rdc(5'h02, DB_DEF_UP);
    rdc(5'h03, DB_DEF_LO);
    wrr(5'h02, 32'h7FFFFFFF);
    rdc(5'h02, DB_MAX);
    wrr(5'h03, 32'h80000000);
    rdc(5'h03, DB_MIN);
    wrr(5'h01, 32'h000000E0);
    rdc(5'h02, DBM_DEF_UP);
    wrr(5'h02, 32'h7FFFFFFF);
    rdc(5'h02, DBM_MAX);
    wrr(5'h03, 32'h80000000);
    rdc(5'h03, DBM_MIN);
    wrr(5'h02, 32'hFFFFE890);
    wrr(5'h03, 32'hFFFFE0C0);
  endtask : t_range

  task automatic t_ttl;
    logic ov0, un0, f, f1;
    // window 1 watches the idle channel b, so it always sits under
    wrr(5'h05, 32'h000000E1);
    for (int k = 0; k < 2; k++) begin
      meas(k ? 32'h00000001 : 32'h000F4240, 32'h00000000);
      ov0 = (k == 0);
      un0 = (k == 1);
      chk({28'h0, ov, un}, {28'h0, 1'b0, ov0, 1'b1, un0});
      // every enable, polarity and condition code
      for (int m = 0; m < 12; m++) begin
        wrr(A_CTRL, {28'h0, m[3:0]});
        @(posedge clk_i);
        @(negedge clk_i);
        f  = (m[3:2] == 2'h0) ? ov0 : (m[3:2] == 2'h1) ? un0 : (ov0 | un0);
        f1 = (m[3:2] != 2'h0);
        chk({31'h0, tu}, {31'h0, (m[0] & f) ? m[1] : !m[1]});
        chk({31'h0, tl}, {31'h0, (m[0] & f1) ? m[1] : !m[1]});
      end
    end
  endtask : t_ttl

  task automatic t_chkoff;
    wrr(5'h01, 32'h000000C0);
    meas(32'h000F4240, 32'h00000000);
    chk({28'h0, ov, un}, 32'h00000002);
    rdc(5'h02, 32'hFFFFE890);
    wrr(5'h01, 32'h000000E0);
  endtask : t_chkoff

  task automatic t_math;
    wrr(A_INT_CLR, 32'h0000003F);
    wrr(A_INT_EN, 32'h00000020);
    wrr(5'h05, 32'h000000E2);
    meas(32'h00000064, 32'h000001F4);
    chk({30'h0, le}, 32'h00000002);
    rdc(A_INT_STAT, 32'h00000020);
    chk({31'h0, irq}, 32'h00000001);
    wrr(A_INT_CLR, 32'h00000020);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h00000000);
    wrr(5'h05, 32'h000000FC);
    meas(32'h00000064, 32'h00000190);
    rdc(5'h08, 32'h000009C4);
    wrr(5'h05, 32'h000000F2);
    meas(32'h00000064, 32'h00000190);
    rdc(5'h08, 32'hFFFFFED4);
  endtask : t_math

  task automatic t_chan;
    wrr(A_CTRL, 32'h00000030);
    meas(32'h000F4240, 32'h00000000);
    chk({28'h0, ov, un}, 32'h00000000);
    wrr(A_CHA_LO, 32'h80000000);
    rdc(A_CHA_LO, DBM_MIN);
    wrr(A_CHA_UP, 32'hFFFFE890);
    meas(32'h000F4240, 32'h00000000);
    chk({28'h0, ov, un}, 32'h00000004);
    rdc(A_STATUS, 32'h00000001);
    @(negedge clk_i);
    chk(rdata, 32'h00000000);
  endtask : t_chan

  initial begin
    rst_i = 1'b1;
    wr    = 1'b0;
    rd    = 1'b0;
    go    = 1'b0;
    addr  = 5'h00;
    wdata = 32'h00000000;
    a_v   = 32'h00000000;
    b_v   = 32'h00000000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_range();
    t_ttl();
    t_chkoff();
    t_math();
    t_chan();
    give_verdict();
  end
endmodule : wlc_top_tb_top
